// ==== src/portable_power_charge_sequencer.sv ====
// power on/off, backup select and charge rate sequencer with axi4-lite registers
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "power_seq_cfg.svh"
module portable_power_charge_sequencer #(
  parameter int CYCLES_PER_SEC = `CFG_CYCLES_PER_SEC,
  parameter int CHARGE_SEC     = `CFG_CHARGE_SEC
) (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // register bus
  input  wire power_seq_pkg::axi_req_t   s_axi_req,
  output power_seq_pkg::axi_rsp_t        s_axi_rsp,
  // power switch, battery and activity inputs
  input  wire logic                      switch_interrupt_in,
  input  wire logic                      battery_low,
  input  wire logic                      key_entry_idle,
  input  wire logic                      io_activity,
  // main cpu handshake and mechanics
  input  wire logic                      cpu_done,
  input  wire logic                      mech_busy,
  // charger inputs
  input  wire logic                      adaptor_detect,
  input  wire logic                      charge_bypass_jumper,
  // supply and reset outputs
  output logic                           supply_enable_n,
  output logic                           backup_source_select,
  output logic                           gate_array_clear,
  output logic                           cpu_power_irq,
  // peripheral outputs: tape, prom, rs232, barcode, speaker
  output logic                           head_unload,
  output logic [4:0]                     periph_power,
  output logic                           printer_reinit,
  // charger output
  output logic                           charge_rate_select
);
  localparam int CW = $clog2(CHARGE_SEC + 1);

  typedef struct packed {
    power_seq_pkg::pwr_state_t st;
    logic [15:0]               step;
    logic                      sw_q;
    logic                      batt_q;
    logic                      warn;
    logic                      soft_on;
    logic                      soft_off;
    logic                      wake_en;
    logic                      aux_sel;
    logic [4:0]                periph;
    logic [31:0]               tod;
    logic [31:0]               wake;
    logic [7:0]                idle_min;
    logic                      aw_full;
    logic                      w_full;
    logic [7:0]                waddr;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    power_seq_pkg::axi_rsp_t   rsp;
    logic                      supply_enable_n;
    logic                      backup_source_select;
    logic                      gate_array_clear;
    logic                      cpu_power_irq;
    logic                      head_unload;
    logic [4:0]                periph_power;
    logic                      printer_reinit;
    logic                      charge_rate_select;
  } seq_state_t;

  seq_state_t s;
  seq_state_t next_s;

  // ----------------------------------------------------------------------------
  // time bases and timers
  // ----------------------------------------------------------------------------
  logic          sec_tick;
  logic          min_tick;
  logic          warn_load;
  logic          idle_load;
  logic          chg_load;
  logic [4:0]    warn_cnt;
  logic [7:0]    idle_cnt;
  logic [CW-1:0] chg_cnt;

  tick_divider #(.DIV(CYCLES_PER_SEC)) u_sec_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .en      (1'b1),
    .tick    (sec_tick)
  );

  tick_divider #(.DIV(`CFG_SEC_PER_MIN)) u_min_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .en      (sec_tick),
    .tick    (min_tick)
  );

  down_timer #(.W(5)) u_warn_tmr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (warn_load),
    .value   (5'(`CFG_WARN_SEC)),
    .tick    (sec_tick),
    .count   (warn_cnt)
  );

  down_timer #(.W(8)) u_idle_tmr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (idle_load),
    .value   (s.idle_min),
    .tick    (min_tick),
    .count   (idle_cnt)
  );

  down_timer #(.W(CW)) u_chg_tmr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (chg_load),
    .value   (CW'(CHARGE_SEC)),
    .tick    (sec_tick),
    .count   (chg_cnt)
  );

  // ----------------------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------------------
  logic on_state;
  logic sw_rise;
  logic sw_fall;
  logic batt_rise;
  logic warn_exp;
  logic idle_exp;
  logic wake_hit;

  assign on_state  = (s.st == power_seq_pkg::ST_ON);
  assign sw_rise   = switch_interrupt_in && !s.sw_q;
  assign sw_fall   = !switch_interrupt_in && s.sw_q;
  assign batt_rise = battery_low && !s.batt_q && on_state;
  assign warn_load = batt_rise;
  assign warn_exp  = s.warn && warn_cnt == 5'h0 && !batt_rise;
  assign idle_load = !on_state || io_activity || !key_entry_idle;
  assign idle_exp  = !idle_load && idle_cnt == 8'h00;
  assign wake_hit  = s.wake_en && s.tod == s.wake;
  assign chg_load  = !adaptor_detect;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  logic        wr_go;
  logic [31:0] ctrl_rd;
  logic [31:0] ctrl_wr;
  logic [31:0] stat_rd;
  logic        step_done;

  always_comb begin
    next_s                = s;
    next_s.sw_q           = switch_interrupt_in;
    next_s.batt_q         = battery_low;
    next_s.printer_reinit = 1'b0;
    step_done             = (s.step >= 16'(`CFG_SEQ_STEP_CYC - 1));
    if (s.step != 16'hFFFF) begin
      next_s.step = s.step + 16'h0001;
    end
    if (sec_tick) begin
      next_s.tod = s.tod + 32'h0000_0001;
    end

    // low-battery warning window
    if (batt_rise) begin
      next_s.warn = 1'b1;
    end else if (warn_exp) begin
      next_s.warn = 1'b0;
    end

    // power sequence
    case (s.st)
      power_seq_pkg::ST_OFF: begin
        if (sw_rise || s.soft_on || wake_hit) begin
          next_s.st      = power_seq_pkg::ST_PWR_UP;
          next_s.step    = 16'h0000;
          next_s.soft_on = 1'b0;
        end
        next_s.soft_off = 1'b0;
      end
      power_seq_pkg::ST_PWR_UP: begin
        if (step_done) begin
          next_s.st = power_seq_pkg::ST_ON;
        end
      end
      power_seq_pkg::ST_ON: begin
        if (sw_fall || (warn_exp && switch_interrupt_in) || idle_exp
            || s.soft_off) begin
          next_s.st       = power_seq_pkg::ST_NOTIFY;
          next_s.step     = 16'h0000;
          next_s.soft_off = 1'b0;
        end
        next_s.soft_on = 1'b0;
      end
      power_seq_pkg::ST_NOTIFY: begin
        if (cpu_done || s.step >= 16'(`CFG_DONE_WAIT_CYC - 1)) begin
          next_s.st = power_seq_pkg::ST_DRAIN;
        end
      end
      power_seq_pkg::ST_DRAIN: begin
        if (!mech_busy) begin
          next_s.st             = power_seq_pkg::ST_HEAD;
          next_s.step           = 16'h0000;
          next_s.printer_reinit = 1'b1;
        end
      end
      power_seq_pkg::ST_HEAD: begin
        if (step_done) begin
          next_s.st   = power_seq_pkg::ST_PERIPH;
          next_s.step = 16'h0000;
        end
      end
      power_seq_pkg::ST_PERIPH: begin
        if (step_done) begin
          next_s.st   = power_seq_pkg::ST_CLEAR;
          next_s.step = 16'h0000;
        end
      end
      power_seq_pkg::ST_CLEAR: begin
        if (step_done) begin
          next_s.st   = power_seq_pkg::ST_OFF;
          next_s.warn = 1'b0;
        end
      end
      default: begin
        next_s.st = power_seq_pkg::ST_OFF;
      end
    endcase

    // register reads
    ctrl_rd = '0;
    ctrl_rd[`CFG_CTRL_WAKE_EN] = s.wake_en;
    ctrl_rd[`CFG_CTRL_AUX_SEL] = s.aux_sel;
    ctrl_rd[`CFG_CTRL_PERIPH_HI:`CFG_CTRL_PERIPH_LO] = s.periph;
    stat_rd    = '0;
    stat_rd[0] = !s.supply_enable_n;
    stat_rd[1] = s.warn;
    stat_rd[2] = s.charge_rate_select;
    stat_rd[3] = adaptor_detect;
    stat_rd[4] = switch_interrupt_in;
    stat_rd[5] = s.gate_array_clear;
    stat_rd[`CFG_STAT_STATE_HI:`CFG_STAT_STATE_LO] = s.st;

    // axi write path
    if (s_axi_req.awvalid && s.rsp.awready) begin
      next_s.aw_full = 1'b1;
      next_s.waddr   = s_axi_req.awaddr;
    end
    if (s_axi_req.wvalid && s.rsp.wready) begin
      next_s.w_full = 1'b1;
      next_s.wdata  = s_axi_req.wdata;
      next_s.wstrb  = s_axi_req.wstrb;
    end
    if (s.rsp.bvalid && s_axi_req.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end
    wr_go   = s.aw_full && s.w_full && !s.rsp.bvalid;
    ctrl_wr = merge(ctrl_rd, s.wdata, s.wstrb);
    if (wr_go) begin
      next_s.aw_full    = 1'b0;
      next_s.w_full     = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp  = 2'b00;
      case (s.waddr)
        `CFG_REG_CTRL: begin
          // request bits set after any consumption above, so a set wins
          if (ctrl_wr[`CFG_CTRL_SOFT_ON]) begin
            next_s.soft_on = 1'b1;
          end
          if (ctrl_wr[`CFG_CTRL_SOFT_OFF]) begin
            next_s.soft_off = 1'b1;
          end
          next_s.wake_en = ctrl_wr[`CFG_CTRL_WAKE_EN];
          next_s.aux_sel = ctrl_wr[`CFG_CTRL_AUX_SEL];
          next_s.periph  = ctrl_wr[`CFG_CTRL_PERIPH_HI:`CFG_CTRL_PERIPH_LO];
        end
        `CFG_REG_TOD: begin
          next_s.tod = merge(s.tod, s.wdata, s.wstrb);
        end
        `CFG_REG_WAKE: begin
          next_s.wake = merge(s.wake, s.wdata, s.wstrb);
        end
        `CFG_REG_IDLE: begin
          if (s.wstrb[0] && s.wdata[7:0] != 8'h00) begin
            next_s.idle_min = s.wdata[7:0];
          end
        end
        `CFG_REG_STATUS: begin
          next_s.rsp.bresp = 2'b00;
        end
        default: begin
          next_s.rsp.bresp = 2'b10;
        end
      endcase
    end
    next_s.rsp.awready = !next_s.aw_full && !next_s.rsp.bvalid;
    next_s.rsp.wready  = !next_s.w_full && !next_s.rsp.bvalid;

    // axi read path
    if (s.rsp.rvalid && s_axi_req.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end
    if (s_axi_req.arvalid && s.rsp.arready) begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rresp  = 2'b00;
      case (s_axi_req.araddr)
        `CFG_REG_CTRL:   next_s.rsp.rdata = ctrl_rd;
        `CFG_REG_TOD:    next_s.rsp.rdata = s.tod;
        `CFG_REG_WAKE:   next_s.rsp.rdata = s.wake;
        `CFG_REG_IDLE:   next_s.rsp.rdata = {24'h00_0000, s.idle_min};
        `CFG_REG_STATUS: next_s.rsp.rdata = stat_rd;
        default: begin
          next_s.rsp.rdata = 32'h0000_0000;
          next_s.rsp.rresp = 2'b10;
        end
      endcase
    end
    next_s.rsp.arready = !next_s.rsp.rvalid;

    // outputs
    next_s.supply_enable_n = (next_s.st == power_seq_pkg::ST_OFF);
    next_s.gate_array_clear = (next_s.st == power_seq_pkg::ST_OFF)
                           || (next_s.st == power_seq_pkg::ST_PWR_UP)
                           || (next_s.st == power_seq_pkg::ST_CLEAR);
    next_s.backup_source_select = !next_s.supply_enable_n
                               && (next_s.aux_sel || battery_low);
    next_s.cpu_power_irq = next_s.warn
                        || (next_s.st == power_seq_pkg::ST_NOTIFY);
    next_s.head_unload = (next_s.st == power_seq_pkg::ST_HEAD)
                      || (next_s.st == power_seq_pkg::ST_PERIPH);
    if (next_s.st == power_seq_pkg::ST_ON || next_s.st == power_seq_pkg::ST_NOTIFY
        || next_s.st == power_seq_pkg::ST_DRAIN || next_s.st == power_seq_pkg::ST_HEAD) begin
      next_s.periph_power = next_s.periph;
    end else begin
      next_s.periph_power = 5'h00;
    end
    // jumper fitted bypasses the rate transistor, so normal rate is shown
    next_s.charge_rate_select = adaptor_detect && !charge_bypass_jumper
                             && chg_cnt == CW'(0);
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s                  <= '0;
      s.st               <= power_seq_pkg::ST_OFF;
      s.step             <= 16'hFFFF;
      s.idle_min         <= `CFG_IDLE_MIN_RESET;
      s.periph           <= `CFG_PERIPH_RESET;
      s.supply_enable_n  <= 1'b1;
      s.gate_array_clear <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_rsp            = s.rsp;
  assign supply_enable_n      = s.supply_enable_n;
  assign backup_source_select = s.backup_source_select;
  assign gate_array_clear     = s.gate_array_clear;
  assign cpu_power_irq        = s.cpu_power_irq;
  assign head_unload          = s.head_unload;
  assign periph_power         = s.periph_power;
  assign printer_reinit       = s.printer_reinit;
  assign charge_rate_select   = s.charge_rate_select;
endmodule : portable_power_charge_sequencer

// ==== include/power_seq_cfg.svh ====
// offsets, field positions, reset values and timing counts of the power sequencer
`ifndef POWER_SEQ_CFG_SVH
`define POWER_SEQ_CFG_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define CFG_REG_CTRL       8'h00
`define CFG_REG_TOD        8'h04
`define CFG_REG_WAKE       8'h08
`define CFG_REG_IDLE       8'h0C
`define CFG_REG_STATUS     8'h10

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CFG_CTRL_SOFT_ON   0
`define CFG_CTRL_SOFT_OFF  1
`define CFG_CTRL_WAKE_EN   2
`define CFG_CTRL_AUX_SEL   3
`define CFG_CTRL_PERIPH_LO 8
`define CFG_CTRL_PERIPH_HI 12
`define CFG_STAT_STATE_LO  8
`define CFG_STAT_STATE_HI  11

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CFG_IDLE_MIN_RESET 8'h0A
`define CFG_PERIPH_RESET   5'h1F

// ----------------------------------------------------------------------------
// times and cycle counts
// ----------------------------------------------------------------------------
`define CFG_CLK_PERIOD_NS  10
`define CFG_SECOND_NS      1000000000
`define CFG_CYCLES_PER_SEC (`CFG_SECOND_NS / `CFG_CLK_PERIOD_NS)
`define CFG_SEC_PER_MIN    60
`define CFG_WARN_SEC       30
`define CFG_CHARGE_HOURS   8
`define CFG_CHARGE_SEC     (`CFG_CHARGE_HOURS * 3600)
`define CFG_SEQ_STEP_NS    160
`define CFG_SEQ_STEP_CYC   ((`CFG_SEQ_STEP_NS + `CFG_CLK_PERIOD_NS - 1) / `CFG_CLK_PERIOD_NS)
`define CFG_DONE_WAIT_NS   10000
`define CFG_DONE_WAIT_CYC  (`CFG_DONE_WAIT_NS / `CFG_CLK_PERIOD_NS)

`endif

// ==== include/power_seq_pkg.sv ====
// types shared by the power and charge sequencer
package power_seq_pkg;

  // ----------------------------------------------------------------------------
  // axi4-lite channels
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  // ----------------------------------------------------------------------------
  // power sequence
  // ----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OFF,
    ST_PWR_UP,
    ST_ON,
    ST_NOTIFY,
    ST_DRAIN,
    ST_HEAD,
    ST_PERIPH,
    ST_CLEAR
  } pwr_state_t;

endpackage : power_seq_pkg

// ==== src/tick_divider.sv ====
// one-cycle tick every DIV enabled cycles
`timescale 1ns/10ps
module tick_divider #(
  parameter int DIV = 60
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // enable and tick
  input  wire logic en,
  output logic      tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } div_state_t;

  div_state_t s;
  div_state_t next_s;

  always_comb begin
    next_s      = s;
    next_s.tick = 1'b0;
    if (en) begin
      if (s.cnt == W'(DIV - 1)) begin
        next_s.cnt  = '0;
        next_s.tick = 1'b1;
      end else begin
        next_s.cnt = s.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule : tick_divider

// ==== src/down_timer.sv ====
// loadable down counter that stops at zero
`timescale 1ns/10ps
module down_timer #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  input  wire logic         tick,
  // state
  output logic [W-1:0]      count
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_state_t;

  tmr_state_t s;
  tmr_state_t next_s;

  always_comb begin
    next_s = s;
    if (load) begin
      next_s.cnt = value;
    end else if (tick && s.cnt != '0) begin
      next_s.cnt = s.cnt - W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign count = s.cnt;
endmodule : down_timer

// ==== tb/power_seq_monitor.sv ====
// assertion checker for the power and charge sequencer
`timescale 1ns/10ps
module power_seq_monitor (
  // clock and reset
  input logic       aclk,
  input logic       aresetn,
  // inputs
  input logic       switch_interrupt_in,
  input logic       adaptor_detect,
  input logic       charge_bypass_jumper,
  input logic       mech_busy,
  // outputs
  input logic       supply_enable_n,
  input logic       backup_source_select,
  input logic       gate_array_clear,
  input logic       cpu_power_irq,
  input logic       head_unload,
  input logic [4:0] periph_power,
  input logic       printer_reinit,
  input logic       charge_rate_select
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_clr_off; $rose(supply_enable_n) |-> $past(gate_array_clear); endproperty
  property p_clr_on; $fell(gate_array_clear) |-> !supply_enable_n; endproperty
  property p_bak_off; supply_enable_n |-> !backup_source_select; endproperty
  property p_per_off; supply_enable_n |-> periph_power == 5'h00; endproperty
  property p_sw_on;
    $rose(switch_interrupt_in) && supply_enable_n |-> ##[1:6] !supply_enable_n;
  endproperty
  property p_rate_up; $rose(charge_rate_select) |-> adaptor_detect && !charge_bypass_jumper;
  endproperty
  property p_rate_lo; !adaptor_detect || charge_bypass_jumper |-> ##2 !charge_rate_select;
  endproperty
  property p_head;
    $rose(head_unload) |-> printer_reinit && !$past(mech_busy);
  endproperty
  a_clr_off: assert property (p_clr_off) else $error("supply cut without clear");
  a_clr_on: assert property (p_clr_on) else $error("clear fell while off");
  a_bak_off: assert property (p_bak_off) else $error("aux backup while off");
  a_per_off: assert property (p_per_off) else $error("peripheral on while off");
  a_sw_on: assert property (p_sw_on) else $error("switch on ignored");
  a_rate_up: assert property (p_rate_up) else $error("trickle without adaptor");
  a_rate_lo: assert property (p_rate_lo) else $error("rate not normal");
  a_head: assert property (p_head) else $error("head unload before reinit");
  c_off: cover property ($rose(supply_enable_n));
  c_rate: cover property ($rose(charge_rate_select));
  c_irq: cover property ($rose(cpu_power_irq));
endmodule : power_seq_monitor

bind portable_power_charge_sequencer power_seq_monitor power_seq_monitor_inst (.*);

// ==== tb/cpu_partner.sv ====
// main cpu model answering the power interrupt
`timescale 1ns/10ps
module cpu_partner (
  // clock
  input  wire logic       aclk,
  // interrupt and answer
  input  wire logic       cpu_power_irq,
  input  wire logic [7:0] lag,
  output logic            cpu_done,
  output logic            mech_busy
);
  logic [7:0] cnt = 8'h00;
  always @(posedge aclk) begin
    cnt       <= cpu_power_irq ? cnt + 8'h01 : 8'h00;
    cpu_done  <= cpu_power_irq && (cnt >= lag);
    mech_busy <= cpu_power_irq;
  end
endmodule : cpu_partner

// ==== tb/portable_power_charge_sequencer_bench.sv ====
// self-checking bench for the power and charge sequencer
`timescale 1ns/10ps
module portable_power_charge_sequencer_bench;
  power_seq_pkg::axi_req_t s_axi_req;
  power_seq_pkg::axi_rsp_t s_axi_rsp;
  logic        aclk, aresetn, switch_interrupt_in, battery_low, key_entry_idle;
  logic        io_activity, cpu_done, mech_busy, adaptor_detect, charge_bypass_jumper;
  logic        supply_enable_n, backup_source_select, gate_array_clear, cpu_power_irq;
  logic        head_unload, printer_reinit, charge_rate_select;
  logic [4:0]  periph_power, p;
  logic [7:0]  lag;
  logic [31:0] d;
  logic [1:0]  r;
  int          bad_count, samples_checked;

  portable_power_charge_sequencer #(.CYCLES_PER_SEC(4), .CHARGE_SEC(20))
    portable_power_charge_sequencer_inst (.aclk, .aresetn, .s_axi_req, .s_axi_rsp,
    .switch_interrupt_in, .battery_low, .key_entry_idle, .io_activity, .cpu_done,
    .mech_busy, .adaptor_detect, .charge_bypass_jumper, .supply_enable_n,
    .backup_source_select, .gate_array_clear, .cpu_power_irq, .head_unload,
    .periph_power, .printer_reinit, .charge_rate_select);
  cpu_partner cpu_partner_inst (.aclk, .cpu_power_irq, .lag, .cpu_done, .mech_busy);

  function automatic logic [31:0] ctrl_word(input logic [4:0] pm, input logic [7:0] lo);
    return {19'h0, pm, lo};
  endfunction : ctrl_word

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    s_axi_req.awaddr  <= a;
    s_axi_req.wdata   <= v;
    s_axi_req.wstrb   <= 4'hF;
    s_axi_req.awvalid <= 1'b1;
    s_axi_req.wvalid  <= 1'b1;
    s_axi_req.bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_rsp.awready) s_axi_req.awvalid <= 1'b0;
      if (s_axi_rsp.wready) s_axi_req.wvalid <= 1'b0;
    end while (!s_axi_rsp.bvalid);
  endtask : axw

  task automatic axr(input logic [7:0] a);
    s_axi_req.araddr  <= a;
    s_axi_req.arvalid <= 1'b1;
    s_axi_req.rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_rsp.arready) s_axi_req.arvalid <= 1'b0;
    end while (!s_axi_rsp.rvalid);
    d = s_axi_rsp.rdata;
    r = s_axi_rsp.rresp;
  endtask : axr

  task automatic summarize();
    $display("mismatches %0d of %0d checks", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    summarize();
  end

  initial begin
    s_axi_req = '0;
    aresetn = 1'b0;
    {switch_interrupt_in, battery_low, key_entry_idle, io_activity} = 4'h0;
    {adaptor_detect, charge_bypass_jumper} = 2'h0;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(62710));
    p = 5'($urandom_range(1, 31));
    lag = 8'($urandom_range(1, 40));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(supply_enable_n, 1'b1);
    chk(gate_array_clear, 1'b1);
    axr(8'h00);
    chk(d, ctrl_word(5'h1F, 8'h00));
    axr(8'hFC);
    chk({r, d}, {2'b10, 32'h0000_0000});
    axw(8'h0C, 32'h0000_0000);
    axr(8'h0C);
    chk(d, 32'h0000_000A);
    axw(8'h0C, 32'h0000_0001);
    axw(8'h00, ctrl_word(p, 8'h00));
    switch_interrupt_in <= 1'b1;
    repeat (24) @(posedge aclk);
    chk({supply_enable_n, gate_array_clear, periph_power}, {2'b00, p});
    switch_interrupt_in <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(cpu_power_irq, 1'b1);
    repeat (lag + 80) @(posedge aclk);
    chk({supply_enable_n, backup_source_select, periph_power}, 7'h40);
    axw(8'h00, ctrl_word(p, 8'h01));
    repeat (24) @(posedge aclk);
    chk(supply_enable_n, 1'b0);
    switch_interrupt_in <= 1'b1;
    battery_low <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({cpu_power_irq, backup_source_select}, 2'b11);
    repeat (lag + 200) @(posedge aclk);
    chk({supply_enable_n, backup_source_select}, 2'b10);
    battery_low <= 1'b0;
    axr(8'h04);
    axw(8'h08, d + 32'h0000_0008);
    axw(8'h00, ctrl_word(p, 8'h0C));
    repeat (60) @(posedge aclk);
    chk({supply_enable_n, backup_source_select}, 2'b01);
    key_entry_idle <= 1'b1;
    repeat (lag + 340) @(posedge aclk);
    chk({supply_enable_n, backup_source_select}, 2'b10);
    key_entry_idle <= 1'b0;
    adaptor_detect <= 1'b1;
    repeat (40) @(posedge aclk);
    chk(charge_rate_select, 1'b0);
    repeat (60) @(posedge aclk);
    chk(charge_rate_select, 1'b1);
    charge_bypass_jumper <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(charge_rate_select, 1'b0);
    summarize();
  end
endmodule : portable_power_charge_sequencer_bench
